// ---- hw/ccr_pkg.sv ----
// Constants, port kinds and the state record of the codec control and rate generator.
package ccr_pkg;

	// Indirect register indices.
	localparam logic [7:0] CCR_IDX_ACCESS = 8'h4E;
	localparam logic [7:0] CCR_IDX_CHIP_CTRL = 8'h80;
	localparam logic [7:0] CCR_IDX_IRQ_EN = 8'h81;
	localparam logic [7:0] CCR_IDX_STATUS = 8'h83;
	localparam logic [7:0] CCR_IDX_RATE_LO = 8'h84;
	localparam logic [7:0] CCR_IDX_RATE_HI = 8'h85;
	localparam logic [7:0] CCR_IDX_RATE_CS = 8'h86;

	// Value that opens the register interface.
	localparam logic [7:0] CCR_ACCESS_KEY = 8'h01;

	// Host address pins as seen in normal and in emulation mode.
	localparam logic [1:0] CCR_SA_0 = 2'h0;
	localparam logic [1:0] CCR_SA_1 = 2'h1;
	localparam logic [1:0] CCR_SA_2 = 2'h2;
	localparam logic [1:0] CCR_SA_3 = 2'h3;

	// Chip control field positions.
	localparam int CCR_CC_MCR = 0;
	localparam int CCR_CC_SOLO = 1;
	localparam int CCR_CC_EMU = 2;

	// Interrupt enable and status field positions.
	localparam int CCR_IE_PLAY = 0;
	localparam int CCR_IE_REC = 1;
	localparam int CCR_IE_POWER = 3;
	localparam int CCR_IE_FIFO_ERR = 4;
	localparam int CCR_IE_TICK = 5;
	localparam int CCR_ST_BUSY = 6;
	localparam int CCR_IE_MASTER = 7;
	localparam logic [7:0] CCR_IE_MASK = 8'hBB;
	localparam logic [7:0] CCR_SRC_MASK = 8'h3B;

	// Rate control/status field positions.
	localparam int CCR_RC_RUN = 0;
	localparam int CCR_RC_FLAG = 1;

	// Rate generator sizes: rate = clock * increment / 2**ACC.
	localparam int CCR_RATE_BITS = 12;
	localparam int CCR_ACC_BITS = 19;

	typedef enum logic [1:0] {
		CCR_PORT_STATUS,
		CCR_PORT_INDEX,
		CCR_PORT_DLOW,
		CCR_PORT_DHIGH
	} ccr_port_type;

	typedef struct packed {
		logic access_on;
		logic [7:0] index;
		logic master_chip_reset;
		logic solo;
		logic emu;
		logic [7:0] ien;
		logic [7:0] hold;
		logic [CCR_RATE_BITS-1:0] rate;
		logic run;
		logic run_sync;
		logic [CCR_ACC_BITS-1:0] acc;
		logic tick;
		logic flag;
		logic irq;
		logic irq_oe;
		logic drq_p;
		logic drq_p_oe;
		logic drq_r;
		logic drq_r_oe;
		logic [7:0] sd_out;
		logic sd_oe;
		logic wr_pend;
		logic [1:0] wr_addr;
		logic [7:0] wr_data;
	} ccr_state_type;

	localparam ccr_state_type CCR_STATE_RESET = '0;

endpackage

// ---- hw/ccr_codec_ctrl.sv ----
// Index/data register core with chip control, interrupt gating and sample rate generator.
`timescale 1ns/100ps

// Behaviour
// R1: Only index writes and writes to the access mode register work until it holds 01h.
// R2: Access mode register clears on hardware reset only, not master reset.
// R3: Emulation mode maps addresses 0..3 to high data, status, low data, index.
// R4: Master reset clears emulation bit; host sets it on a later write.
// R5: Solo mode makes status and index readable at offsets 0 and 1.
// R6: Shared mode keeps status only at 83h; offsets 0 and 1 undriven.
// R7: Solo drives request and interrupt pins both ways; shared drives high only.
// R8: Solo bit clears on hardware reset only.
// R9: Chip control bit 0 low holds functions in reset; pin reset clears it.
// R10: Master interrupt enable low keeps interrupt pin low; cleared by master reset.
// R11: Individual enables gate sources into status and pin, sources untouched.
// R12: Master reset clears all individual interrupt enables.
// R13: Register 83h mirrors status and is readable in shared mode.
// R14: Rate is clock times 12-bit increment over 524288; low byte, high nibble.
// R15: Increment registers are not touched by any reset.
// R16: Host should stop the generator before changing the increment.
// R17: Tick flag sets on every accumulator overflow; the code drops an overflow that lands once run or master reset is already low.
// R18: Tick flag clears on master reset, run low, status bit 5, rate control write.
// R19: Run low resets counter and flag; run high starts generation.
// R20: Run bit is resynchronised to the clock; master reset clears it.
// R21: Reserved bits read as zero; host writes them zero.
// R22: Indirect registers are 8 bits through the low data port.
// R23: Writing one to a status bit clears and holds it; zero re-arms.
// R24: The index register is a read/write pointer for the data ports.
// R25: The counter is a 19-bit accumulator adding the increment every clock.
// R26: Interrupt pin is high when master enable and an enabled pending source.
module ccr_codec_ctrl (
	// Clock and hardware reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Host bus, synchronous to core_clk.
	input wire logic cs_n,
	input wire logic iow_n,
	input wire logic ior_n,
	input wire logic [1:0] sa,
	input wire logic [7:0] sd_in,
	output logic [7:0] sd_out,
	output logic sd_oe,
	// Interrupt sources and the play FIFO full status from the rest of the chip.
	input wire logic play_fifo_src,
	input wire logic record_fifo_src,
	input wire logic power_change_src,
	input wire logic fifo_error_src,
	input wire logic play_fifo_full,
	// Request sources from the DMA engines.
	input wire logic play_dma_request_src,
	input wire logic record_dma_request_src,
	// Pins with mode-dependent drive.
	output logic irq,
	output logic irq_oe,
	output logic play_dma_request,
	output logic play_dma_request_oe,
	output logic record_dma_request,
	output logic record_dma_request_oe,
	// Controls to the rest of the chip.
	output logic master_chip_reset_n,
	output logic solo_mode,
	output logic legacy_port_emulation_mode,
	output logic sample_rate_run,
	output logic sample_tick,
	output logic [ccr_pkg::CCR_RATE_BITS-1:0] rate_increment
);
	import ccr_pkg::*;

	ccr_state_type st_q;
	ccr_state_type st_d;
	logic commit;
	logic rd_active;
	ccr_port_type wr_port;
	ccr_port_type rd_port;
	logic [7:0] sources;
	logic [7:0] pending;
	logic [7:0] status_v;
	logic [CCR_ACC_BITS:0] acc_sum;
	logic carry;
	logic flag_clr;

	// Host address decode; emulation swaps the pins onto a parallel-port layout.
	function automatic ccr_port_type port_of(input logic [1:0] addr, input logic emu);
		ccr_port_type p;
		p = CCR_PORT_DHIGH;
		if (emu) begin
			unique case (addr)
				CCR_SA_0: p = CCR_PORT_DHIGH; // see R3
				CCR_SA_1: p = CCR_PORT_STATUS;
				CCR_SA_2: p = CCR_PORT_DLOW;
				CCR_SA_3: p = CCR_PORT_INDEX;
			endcase
		end else begin
			unique case (addr)
				CCR_SA_0: p = CCR_PORT_STATUS;
				CCR_SA_1: p = CCR_PORT_INDEX;
				CCR_SA_2: p = CCR_PORT_DLOW; // see R22
				CCR_SA_3: p = CCR_PORT_DHIGH;
			endcase
		end
		return p;
	endfunction

	// Indirect read mux; unlisted and write-only indices return zero.
	function automatic logic [7:0] reg_read(input ccr_state_type s, input logic [7:0] stat);
		logic [7:0] v;
		v = 8'h00; // see R21
		unique case (s.index)
			CCR_IDX_CHIP_CTRL: v = {5'h00, s.emu, s.solo, s.master_chip_reset};
			CCR_IDX_IRQ_EN: v = s.ien & CCR_IE_MASK;
			CCR_IDX_STATUS: v = stat; // see R13
			CCR_IDX_RATE_LO: v = s.rate[7:0];
			CCR_IDX_RATE_HI: v = {4'h0, s.rate[11:8]};
			CCR_IDX_RATE_CS: v = {6'h00, s.flag, s.run};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Hold bits let software silence a source; the source itself is not altered.
	assign sources = {2'b00, st_q.flag, fifo_error_src, power_change_src, 1'b0,
		record_fifo_src, play_fifo_src};
	assign pending = sources & st_q.ien & ~st_q.hold & CCR_SRC_MASK; // see R11, R23
	assign status_v = {st_q.irq, ~play_fifo_full, pending[5:0]};

	assign commit = st_q.wr_pend & iow_n;
	assign rd_active = ~cs_n & ~ior_n;
	assign wr_port = port_of(st_q.wr_addr, st_q.emu);
	assign rd_port = port_of(sa, st_q.emu);

	// Phase accumulator; the carry out of the top bit is one sample period.
	assign acc_sum = {1'b0, st_q.acc} + {{(CCR_ACC_BITS + 1 - CCR_RATE_BITS){1'b0}}, st_q.rate};
	assign carry = acc_sum[CCR_ACC_BITS]; // see R14, R25

	always_comb begin
		st_d = st_q;
		flag_clr = 1'b0;

		// The write is committed on the rising strobe, when the data has settled.
		if (!cs_n && !iow_n) begin
			st_d.wr_pend = 1'b1;
			st_d.wr_addr = sa;
			st_d.wr_data = sd_in;
		end else if (commit) begin
			st_d.wr_pend = 1'b0;
		end

		if (commit) begin
			unique case (wr_port)
				CCR_PORT_INDEX: begin
					st_d.index = st_q.wr_data; // see R1, R24
				end
				CCR_PORT_STATUS: begin
					if (st_q.access_on) begin
						st_d.hold = st_q.wr_data & CCR_SRC_MASK; // see R23
						flag_clr = st_q.wr_data[CCR_IE_TICK]; // see R18
					end
				end
				CCR_PORT_DLOW: begin
					// The key register must stay writable while the interface is locked.
					if (st_q.access_on || st_q.index == CCR_IDX_ACCESS) begin // see R1
						unique case (st_q.index)
							CCR_IDX_ACCESS: begin
								st_d.access_on = (st_q.wr_data == CCR_ACCESS_KEY);
							end
							CCR_IDX_CHIP_CTRL: begin
								st_d.master_chip_reset = st_q.wr_data[CCR_CC_MCR];
								st_d.solo = st_q.wr_data[CCR_CC_SOLO];
								st_d.emu = st_q.wr_data[CCR_CC_EMU];
							end
							CCR_IDX_IRQ_EN: begin
								st_d.ien = st_q.wr_data & CCR_IE_MASK;
							end
							CCR_IDX_RATE_LO: begin
								st_d.rate[7:0] = st_q.wr_data; // see R14
							end
							CCR_IDX_RATE_HI: begin
								st_d.rate[11:8] = st_q.wr_data[3:0];
							end
							CCR_IDX_RATE_CS: begin
								st_d.run = st_q.wr_data[CCR_RC_RUN]; // see R19
								flag_clr = 1'b1; // see R18
							end
							default: begin
							end
						endcase
					end
				end
				CCR_PORT_DHIGH: begin
				end
			endcase
		end

		// Run is retimed once so the accumulator never starts on a half-written value.
		st_d.run_sync = st_q.run; // see R20
		if (st_q.run_sync) begin
			st_d.acc = acc_sum[CCR_ACC_BITS-1:0]; // see R25
			st_d.tick = carry;
		end else begin
			st_d.acc = '0; // see R19
			st_d.tick = 1'b0;
		end

		// A tick that lands on a clearing write is kept.
		if (flag_clr) begin
			st_d.flag = 1'b0;
		end
		if (st_q.run_sync && carry) begin
			st_d.flag = 1'b1; // see R17
		end
		if (!st_q.run) begin
			st_d.flag = 1'b0; // see R18, R19
		end

		// Master reset holds the resettable functions; access and solo survive it.
		if (!st_q.master_chip_reset) begin // see R9, R2, R8
			st_d.emu = 1'b0; // see R4
			st_d.ien = 8'h00; // see R10, R12
			st_d.hold = 8'h00;
			st_d.run = 1'b0; // see R20
			st_d.run_sync = 1'b0;
			st_d.acc = '0;
			st_d.tick = 1'b0;
			st_d.flag = 1'b0; // see R18
		end

		// Shared mode sources only the high level so several chips can share a wire.
		st_d.irq = st_q.ien[CCR_IE_MASTER] & (|pending); // see R10, R26
		st_d.irq_oe = st_q.solo | st_d.irq; // see R7
		st_d.drq_p = play_dma_request_src;
		st_d.drq_p_oe = st_q.solo | play_dma_request_src;
		st_d.drq_r = record_dma_request_src;
		st_d.drq_r_oe = st_q.solo | record_dma_request_src;

		// Reads are answered one clock after the strobe is seen.
		st_d.sd_oe = 1'b0;
		st_d.sd_out = 8'h00;
		if (rd_active && st_q.access_on) begin // see R1
			unique case (rd_port)
				CCR_PORT_STATUS: begin
					st_d.sd_oe = st_q.solo; // see R5, R6
					st_d.sd_out = status_v;
				end
				CCR_PORT_INDEX: begin
					st_d.sd_oe = st_q.solo; // see R5, R6, R24
					st_d.sd_out = st_q.index;
				end
				CCR_PORT_DLOW: begin
					st_d.sd_oe = 1'b1; // see R22
					st_d.sd_out = reg_read(st_q, status_v);
				end
				CCR_PORT_DHIGH: begin
					st_d.sd_oe = 1'b1; // see R21
					st_d.sd_out = 8'h00;
				end
			endcase
		end

		// Hardware reset clears everything except the increment, which has no reset.
		if (!rst_n) begin
			st_d = CCR_STATE_RESET; // see R2, R8, R9
			st_d.rate = st_q.rate; // see R15
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	assign sd_out = st_q.sd_out;
	assign sd_oe = st_q.sd_oe;
	assign irq = st_q.irq;
	assign irq_oe = st_q.irq_oe;
	assign play_dma_request = st_q.drq_p;
	assign play_dma_request_oe = st_q.drq_p_oe;
	assign record_dma_request = st_q.drq_r;
	assign record_dma_request_oe = st_q.drq_r_oe;
	assign master_chip_reset_n = st_q.master_chip_reset;
	assign solo_mode = st_q.solo;
	assign legacy_port_emulation_mode = st_q.emu;
	assign sample_rate_run = st_q.run_sync;
	assign sample_tick = st_q.tick;
	assign rate_increment = st_q.rate;

	// Checks on the behaviour above.
	sequence s_flag_then_idle;
		!st_q.flag ##1 (st_q.acc == '0);
	endsequence

	sequence s_shared_steady;
		!st_q.solo ##1 !st_q.solo;
	endsequence

	property p_locked_no_read;
		@(posedge core_clk) disable iff (!rst_n)
		!st_q.access_on |=> !sd_oe;
	endproperty
	a_locked_no_read: assert property (p_locked_no_read) else $error("read driven while locked"); // see R1

	property p_access_survives_mcr;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(st_q.master_chip_reset) |-> st_q.access_on == $past(st_q.access_on) && st_q.solo == $past(st_q.solo);
	endproperty
	a_access_survives_mcr: assert property (p_access_survives_mcr) else $error("mcr hit access or solo"); // see R2

	property p_emu_index;
		@(posedge core_clk) disable iff (!rst_n)
		commit && st_q.emu && st_q.wr_addr == CCR_SA_3 |=> st_q.index == $past(st_q.wr_data);
	endproperty
	a_emu_index: assert property (p_emu_index) else $error("emulation index write lost"); // see R3

	property p_shared_no_status_read;
		@(posedge core_clk) disable iff (!rst_n)
		rd_active && !st_q.solo && (rd_port == CCR_PORT_STATUS || rd_port == CCR_PORT_INDEX)
			|=> !sd_oe;
	endproperty
	a_shared_no_status_read: assert property (p_shared_no_status_read) else $error("shared read driven"); // see R6

	property p_shared_drive;
		@(posedge core_clk) disable iff (!rst_n)
		s_shared_steady |-> (irq_oe == irq) && (play_dma_request_oe == play_dma_request);
	endproperty
	a_shared_drive: assert property (p_shared_drive) else $error("shared pin drove low"); // see R7

	property p_mie_low;
		@(posedge core_clk) disable iff (!rst_n)
		!st_q.ien[CCR_IE_MASTER] |=> !irq;
	endproperty
	a_mie_low: assert property (p_mie_low) else $error("irq with master enable low"); // see R10

	property p_mcr_clears;
		@(posedge core_clk) disable iff (!rst_n)
		!st_q.master_chip_reset |=> st_q.ien == 8'h00 && !st_q.emu && !st_q.run;
	endproperty
	a_mcr_clears: assert property (p_mcr_clears) else $error("master reset left state"); // see R12

	property p_tick_sets_flag;
		@(posedge core_clk) disable iff (!rst_n)
		st_q.run_sync && carry && st_q.run && st_q.master_chip_reset |=> st_q.flag && sample_tick;
	endproperty
	a_tick_sets_flag: assert property (p_tick_sets_flag) else $error("overflow lost"); // see R17

	property p_run_low_clears;
		@(posedge core_clk) disable iff (!rst_n)
		!st_q.run ##1 !st_q.run |=> s_flag_then_idle;
	endproperty
	a_run_low_clears: assert property (p_run_low_clears) else $error("stopped counter moved"); // see R19

	property p_run_sync;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(st_q.run) && st_q.master_chip_reset |-> !st_q.run_sync ##1 st_q.run_sync;
	endproperty
	a_run_sync: assert property (p_run_sync) else $error("run not retimed by one clock"); // see R20

	property p_irq_follows;
		@(posedge core_clk) disable iff (!rst_n)
		st_q.ien[CCR_IE_MASTER] && (|pending) |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("pending source gave no irq"); // see R26

	property p_access_key;
		@(posedge core_clk) disable iff (!rst_n)
		commit && wr_port == CCR_PORT_DLOW && st_q.index == CCR_IDX_ACCESS
			|=> st_q.access_on == ($past(st_q.wr_data) == CCR_ACCESS_KEY);
	endproperty
	a_access_key: assert property (p_access_key) else $error("access key not applied"); // see R1

	property p_solo_status;
		@(posedge core_clk) disable iff (!rst_n)
		rd_active && st_q.access_on && st_q.solo && rd_port == CCR_PORT_STATUS
			|=> sd_oe && sd_out == $past(status_v);
	endproperty
	a_solo_status: assert property (p_solo_status) else $error("solo status read lost"); // see R5

	property p_status_hold;
		@(posedge core_clk) disable iff (!rst_n)
		commit && wr_port == CCR_PORT_STATUS && st_q.access_on && st_q.master_chip_reset
			|=> st_q.hold == ($past(st_q.wr_data) & CCR_SRC_MASK);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status write not held"); // see R23

	// A carry in the same cycle as the write keeps the flag, so it is left out here.
	property p_rate_write_clears;
		@(posedge core_clk) disable iff (!rst_n)
		commit && wr_port == CCR_PORT_DLOW && st_q.access_on && st_q.index == CCR_IDX_RATE_CS
			&& !(st_q.run_sync && carry) |=> !st_q.flag;
	endproperty
	a_rate_write_clears: assert property (p_rate_write_clears) else $error("flag kept"); // see R18

endmodule

// ---- sim/ccr_host_model.sv ----
// Host bus master model that runs single byte cycles on the register port.
`timescale 1ns/100ps
module ccr_host_model (
	// Clock.
	input wire logic core_clk,
	// Host bus.
	output logic cs_n,
	output logic iow_n,
	output logic ior_n,
	output logic [1:0] sa,
	output logic [7:0] sd_in,
	input wire logic [7:0] sd_out,
	input wire logic sd_oe
);
	initial begin
		{cs_n, iow_n, ior_n} = 3'h7;
		sa = 2'h0;
		sd_in = 8'h00;
	end

	// Released data lines flip, so a stale byte can never pass for a fresh one.
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(negedge core_clk);
		{cs_n, iow_n} = 2'h0;
		sa = a;
		sd_in = v;
		@(negedge core_clk);
		{cs_n, iow_n} = 2'h3;
		sd_in = ~v;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic rd(input logic [1:0] a, output logic oe, output logic [7:0] v);
		@(negedge core_clk);
		{cs_n, ior_n} = 2'h0;
		sa = a;
		@(negedge core_clk);
		oe = sd_oe;
		// An undriven bus reads back inverted, so a missing drive can never pass.
		v = sd_oe ? sd_out : ~sd_out;
		{cs_n, ior_n} = 2'h3;
	endtask
endmodule

// ---- sim/test_codec_chip_control_and_rate_gen.sv ----
// Self-checking bench for the codec control and rate generator.
`timescale 1ns/100ps
module test_codec_chip_control_and_rate_gen;
	import ccr_pkg::*;
	logic core_clk, rst_n, cs_n, iow_n, ior_n, sd_oe, irq, irq_oe, full, oe;
	logic p_req, p_oe, r_req, r_oe, mrst_n, solo, emu, run, tick;
	logic [1:0] sa, dreq;
	logic [3:0] src, hi;
	logic [7:0] sd_in, sd_out, d, lo, m_cc, m_ien, m_hold;
	logic [8:0] seq [5] = '{9'h010, 9'h090, 9'h110, 9'h100, 9'h080};
	logic [11:0] inc;
	int n_mismatch, checked, seed, n, i;

	ccr_host_model host (.core_clk(core_clk), .cs_n(cs_n), .iow_n(iow_n), .ior_n(ior_n),
		.sa(sa), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe));

	ccr_codec_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .iow_n(iow_n),
		.ior_n(ior_n), .sa(sa), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
		.play_fifo_src(src[0]), .record_fifo_src(src[1]), .power_change_src(src[2]),
		.fifo_error_src(src[3]), .play_fifo_full(full), .play_dma_request_src(dreq[0]),
		.record_dma_request_src(dreq[1]), .irq(irq), .irq_oe(irq_oe),
		.play_dma_request(p_req), .play_dma_request_oe(p_oe), .record_dma_request(r_req),
		.record_dma_request_oe(r_oe), .master_chip_reset_n(mrst_n), .solo_mode(solo),
		.legacy_port_emulation_mode(emu), .sample_rate_run(run), .sample_tick(tick),
		.rate_increment(inc));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		n_mismatch++;
		summarize();
	end

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
		host.wr(m_cc[2] ? CCR_SA_3 : CCR_SA_1, idx);
		host.wr(CCR_SA_2, v);
	endtask

	task automatic rreg(input logic [7:0] idx);
		host.wr(m_cc[2] ? CCR_SA_3 : CCR_SA_1, idx);
		host.rd(CCR_SA_2, oe, d);
	endtask

	// Model of chip control: a low reset bit wipes emulation, enables and holds.
	task automatic wcc(input logic [7:0] v);
		wreg(CCR_IDX_CHIP_CTRL, v);
		m_cc = v[0] ? v : (v & 8'h02);
		if (!v[0])
			{m_ien, m_hold} = '0;
	endtask

	function automatic logic [7:0] exp_st();
		logic [7:0] s;
		s = {3'h0, src[3], src[2], 1'b0, src[1], src[0]} & m_ien & ~m_hold & CCR_SRC_MASK;
		s[7] = m_ien[7] & (|s[5:0]);
		s[6] = ~full;
		return s;
	endfunction

	task automatic chk_st();
		logic [7:0] e;
		dreq = 2'($random(seed));
		if (m_cc[1])
			host.rd(m_cc[2] ? CCR_SA_1 : CCR_SA_0, oe, d);
		else
			rreg(CCR_IDX_STATUS);
		e = exp_st();
		chk("status", e, d);
		chk("irq", e[7], irq);
		chk("irq drive", m_cc[1] | e[7], irq_oe);
		chk("play request", dreq[0], p_req);
		chk("record request drive", m_cc[1] | dreq[1], r_oe);
		chk("play request drive", m_cc[1] | dreq[0], p_oe);
		chk("record request", dreq[1], r_req);
	endtask

	initial begin
		seed = 32'h33D0E9C6;
		{rst_n, src, full, dreq, m_cc, m_ien, m_hold} = '0;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		wreg(CCR_IDX_CHIP_CTRL, 8'h03);
		rreg(CCR_IDX_CHIP_CTRL);
		chk("locked drive", 1'b0, oe);
		chk("solo", 1'b0, solo);
		wreg(CCR_IDX_ACCESS, CCR_ACCESS_KEY);
		rreg(CCR_IDX_CHIP_CTRL);
		chk("chip control", 8'h00, d);
		host.rd(CCR_SA_1, oe, d);
		chk("shared index drive", 1'b0, oe);
		wcc(8'h03);
		chk("reset out", 1'b1, mrst_n);
		host.rd(CCR_SA_1, oe, d);
		chk("index", CCR_IDX_CHIP_CTRL, d);
		chk_st();
		wcc(8'h07);
		chk("emulation", 1'b1, emu);
		host.rd(CCR_SA_3, oe, d);
		chk("emulated index", CCR_IDX_CHIP_CTRL, d);
		host.rd(CCR_SA_2, oe, d);
		chk("emulated data", 8'h07, d);
		host.rd(CCR_SA_0, oe, d);
		chk("high data", 8'h00, d);
		chk_st();
		wcc(8'h03);
		lo = 8'($random(seed));
		hi = 4'h8;
		wreg(CCR_IDX_RATE_LO, lo);
		wreg(CCR_IDX_RATE_HI, {4'h0, hi});
		chk("increment", {hi, lo}, inc);
		rreg(CCR_IDX_RATE_HI);
		chk("high nibble", {4'h0, hi}, d);
		wreg(CCR_IDX_RATE_CS, 8'h01);
		chk("run", 1'b1, run);
		n = 0;
		repeat (4096) begin
			@(negedge core_clk);
			n += tick;
		end
		chk("tick count", 1'b1, n >= {hi, lo} / 128 - 1 && n <= {hi, lo} / 128 + 1);
		rreg(CCR_IDX_RATE_CS);
		chk("rate status", 8'h03, d);
		// Clearing right after a tick leaves a full period before the flag can return.
		for (i = 0; i < 300 && tick !== 1'b1; i++)
			@(negedge core_clk);
		chk("tick seen", 1'b1, tick);
		if (tick !== 1'b1)
			summarize();
		host.wr(CCR_SA_2, 8'h01);
		host.rd(CCR_SA_2, oe, d);
		chk("flag cleared", 8'h01, d);
		for (i = 0; i < 300 && tick !== 1'b1; i++)
			@(negedge core_clk);
		chk("second tick", 1'b1, tick);
		host.wr(CCR_SA_0, 8'h20);
		host.wr(CCR_SA_0, 8'h00);
		host.rd(CCR_SA_2, oe, d);
		chk("flag cleared by status", 8'h01, d);
		wreg(CCR_IDX_RATE_CS, 8'h00);
		rreg(CCR_IDX_RATE_CS);
		chk("stopped", 8'h00, d);
		chk("run off", 1'b0, run);
		src = {1'b1, 3'($random(seed))};
		full = 1'($random(seed));
		for (i = 0; i < 5; i++) begin
			if (seq[i][8]) begin
				host.wr(CCR_SA_0, seq[i][7:0]);
				m_hold = seq[i][7:0] & CCR_SRC_MASK;
			end else begin
				wreg(CCR_IDX_IRQ_EN, seq[i][7:0]);
				m_ien = seq[i][7:0];
			end
			chk_st();
		end
		wcc(8'h01);
		host.rd(CCR_SA_0, oe, d);
		chk("shared status drive", 1'b0, oe);
		wreg(CCR_IDX_IRQ_EN, 8'hFF);
		m_ien = CCR_IE_MASK;
		rreg(CCR_IDX_IRQ_EN);
		chk("enables", CCR_IE_MASK, d);
		chk_st();
		src = 4'h0;
		chk_st();
		wcc(8'h07);
		chk("emulation set", 1'b1, emu);
		wcc(8'h06);
		chk("emulation cleared", 1'b0, emu);
		chk("solo kept", 1'b1, solo);
		chk("reset out low", 1'b0, mrst_n);
		rreg(CCR_IDX_IRQ_EN);
		chk("enables cleared", 8'h00, d);
		chk("access kept", 1'b1, oe);
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		{m_cc, m_ien, m_hold} = '0;
		chk("increment kept", {hi, lo}, inc);
		wreg(CCR_IDX_CHIP_CTRL, 8'h03);
		chk("solo after reset", 1'b0, solo);
		rreg(CCR_IDX_CHIP_CTRL);
		chk("relocked", 1'b0, oe);
		summarize();
	end
endmodule
